// ===== common/ssc_defines.vh
// constants of the synthesizer serial programming port and frame-reference
// pulse logic; included by every design file of the block
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// ------------------------------------------------------------
// serial frame layout
// ------------------------------------------------------------
`define SSC_FRAME_BITS 24
`define SSC_ADDR_BITS 7
`define SSC_DATA_BITS 16
`define SSC_RW_POS 23
`define SSC_ADDR_MSB 22
`define SSC_ADDR_LSB 16
`define SSC_RW_WRITE 1'h0
`define SSC_RW_READ 1'h1

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define SSC_ADDR_MAIN 7'h00
`define SSC_ADDR_INFMT 7'h3A
`define SSC_ADDR_DLY_A 7'h3C
`define SSC_ADDR_DLY_B 7'h3D
`define SSC_ADDR_FRCFG 7'h47
`define SSC_ADDR_FRDIV 7'h48

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SSC_MAIN_PD 0
`define SSC_MAIN_RST 1
`define SSC_MAIN_CAL 3
`define SSC_MAIN_PSYNC 14
`define SSC_FRCFG_PULSED 1
`define SSC_FRCFG_REPEAT 2
`define SSC_FRCFG_EN 3
`define SSC_FRCFG_PDIV_LSB 5
`define SSC_FRCFG_CNT_LSB 12
`define SSC_INFMT_FMT_LSB 9
`define SSC_INFMT_LVL_LSB 7
`define SSC_INFMT_HYST 15
`define SSC_INFMT_LVDS 3'h1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SSC_RST_MAIN 16'h0000
`define SSC_RST_INFMT 16'h0000
`define SSC_RST_DLY_A 16'h06E4
`define SSC_RST_DLY_B 16'h0000
`define SSC_RST_FRCFG 16'h4020
`define SSC_RST_FRDIV 16'h0000
`define SSC_RST_OTHER 16'h0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SSC_OUT_STEPS 16
`define SSC_MAX_DELAY_NS 1

`endif

// ===== rtl/ssc_regmem.v
// register store of the serial port: 128 words of 16 bits with registered
// read data; words never written since the last clear read as reset values
// assumes one clock, a synchronous clear and one write or read per cycle
`timescale 1ns/1ps
`include "ssc_defines.vh"

module ssc_regmem #(
    parameter AW = 7, // address width
    parameter DW = 16 // data width
) (
    input wire clk_in, // block clock
    input wire clear_in, // return every word to its reset value
    input wire wr_in, // write strobe
    input wire [AW-1:0] addr_in, // word address
    input wire [DW-1:0] wdata_in, // write data
    output reg [DW-1:0] rdata_out // read data of addr_in, one cycle later
);

    reg [DW-1:0] mem [0:(1<<AW)-1]; // storage array
    reg [(1<<AW)-1:0] valid_q; // word written since last clear

    // ------------------------------------------------------------
    // reset value of a word, shared by read path
    // ------------------------------------------------------------
    function [DW-1:0] ssc_rst_val;
        input [AW-1:0] a;
        begin
            case (a)
                `SSC_ADDR_MAIN: ssc_rst_val = `SSC_RST_MAIN;
                `SSC_ADDR_INFMT: ssc_rst_val = `SSC_RST_INFMT;
                `SSC_ADDR_DLY_A: ssc_rst_val = `SSC_RST_DLY_A;
                `SSC_ADDR_DLY_B: ssc_rst_val = `SSC_RST_DLY_B;
                `SSC_ADDR_FRCFG: ssc_rst_val = `SSC_RST_FRCFG;
                `SSC_ADDR_FRDIV: ssc_rst_val = `SSC_RST_FRDIV;
                default: ssc_rst_val = `SSC_RST_OTHER;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // array write; the valid vector avoids a 128-word reset sweep
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    // valid bits: clear wins, a write sets its word
    always @(posedge clk_in) begin
        if (clear_in) begin
            valid_q <= {(1<<AW){1'b0}};
        end else if (wr_in) begin
            valid_q[addr_in] <= 1'b1;
        end
    end

    // registered read
    always @(posedge clk_in) begin
        if (valid_q[addr_in]) begin
            rdata_out <= mem[addr_in];
        end else begin
            rdata_out <= ssc_rst_val(addr_in);
        end
    end

endmodule

// ===== rtl/ssc_ctrl.v
// serial programming port, device modes and frame-reference pulse logic
// of a synthesizer; all pins are asynchronous to clk_in and are brought in
// through two flip-flops; the output clock is modelled by a divider enable
`timescale 1ns/1ps
`include "ssc_defines.vh"

// Operation
// - frame is flag, address, data
// - flag zero writes, one reads
// - shift on rising serial clock, MSB first
// - select rise commits data to address
// - reset bit without powerdown restores registers
// - powerdown bit or chip enable low
// - phase sync routes divider into feedback
// - reference mode needs sync and enable
// - repeater echoes request, resampled twice
// - phase steps of one sixteenth period
// - bursts of 1,2,4,8 or continuous
// - pulse rate is output over divider
// - request toggles start bursts when repeating
// - differential request only when repeating
// - LVDS applies bias level and hysteresis
// - generator makes pulses, repeater follows request
// - pulsed mode emits burst_pulse_count pulses
module ssc_ctrl #(
    parameter OUT_DIV = `SSC_OUT_STEPS, // clk cycles per main output period
    parameter MAX_STEPS = 15 // largest phase delay in steps
) (
    input wire clk_in, // 20 MHz block clock
    input wire rst_in, // synchronous reset, active high
    input wire serial_clk_in, // serial clock pin
    input wire serial_data_in, // serial data pin
    input wire serial_select_n_in, // chip select pin, active low
    input wire chip_enable_in, // chip enable pin, low powers down
    input wire reference_clock_in, // reference clock pin
    input wire pulse_request_pin_in, // frame-reference request pin
    output reg readback_out, // serial readback data
    output wire powerdown_out, // device powered down
    output wire sync_feedback_out, // channel divider in feedback path
    output reg calibration_start_out, // one-cycle calibration start pulse
    output wire frame_ref_mode_out, // frame-reference mode active
    output reg secondary_output_out, // frame-reference pulse output
    output reg main_output_out, // modelled main output clock
    output wire [2:0] frame_ref_prediv_out, // pre-divider setting
    output wire lvds_in_en_out, // request input in differential format
    output wire [1:0] input_bias_level_out, // applied input bias level
    output wire input_hysteresis_out, // applied input hysteresis
    output wire [23:0] delay_interp_ctrl_out // four 6-bit delay words
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [5:0] sync1_q; // first stage, read only by sync2_q
    reg [5:0] sync2_q; // second stage
    reg sclk_d1_q;     // delayed serial clock for edge finding
    reg csn_d1_q;      // delayed chip select for edge finding
    reg refc_d1_q;     // delayed reference clock for edge finding

    always @(posedge clk_in) begin
        if (rst_in) begin
            // idle pin levels, so no false edge follows reset
            sync1_q <= 6'h2C;
            sync2_q <= 6'h2C;
        end else begin
            sync1_q <= {pulse_request_pin_in, reference_clock_in,
                chip_enable_in, serial_select_n_in, serial_data_in,
                serial_clk_in};
            sync2_q <= sync1_q;
        end
    end

    wire sclk_s = sync2_q[0];
    wire sdi_s = sync2_q[1];
    wire csn_s = sync2_q[2];
    wire ce_s = sync2_q[3];
    wire refc_s = sync2_q[4];
    wire req_s = sync2_q[5];

    always @(posedge clk_in) begin
        if (rst_in) begin
            sclk_d1_q <= 1'b0;
            csn_d1_q <= 1'b1;
            refc_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
            csn_d1_q <= csn_s;
            refc_d1_q <= refc_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d1_q;
    wire sclk_fall = ~sclk_s & sclk_d1_q;
    wire cs_start = ~csn_s & csn_d1_q;
    wire cs_end = csn_s & ~csn_d1_q;
    wire ref_tick = refc_s & ~refc_d1_q;

    // ------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------
    reg [23:0] shift_q;   // received frame bits
    reg [4:0] bitcnt_q;   // bits received this frame
    reg [15:0] rd_shift_q; // readback bits still to send
    reg rd_load_q;        // memory read data due this cycle
    reg soft_clr_q;       // software reset in progress
    wire [15:0] mem_rdata; // registered memory read data

    wire frame_ok = (bitcnt_q == `SSC_FRAME_BITS);
    wire wr_frame = cs_end & frame_ok &
        (shift_q[`SSC_RW_POS] == `SSC_RW_WRITE);
    wire [6:0] wr_addr = shift_q[`SSC_ADDR_MSB:`SSC_ADDR_LSB];
    wire [15:0] wr_data = shift_q[15:0];
    // the address is complete once eight bits have arrived
    wire rd_issue = sclk_rise & ~csn_s & (bitcnt_q == 5'h07) &
        (shift_q[6] == `SSC_RW_READ);
    wire [6:0] mem_addr = wr_frame ? wr_addr : {shift_q[5:0], sdi_s};

    // shift on sampled rising edges while selected
    always @(posedge clk_in) begin
        if (rst_in) begin
            shift_q <= 24'h000000;
            bitcnt_q <= 5'h00;
        end else if (cs_start) begin
            bitcnt_q <= 5'h00;
        end else if (sclk_rise & ~csn_s) begin
            shift_q <= {shift_q[22:0], sdi_s};
            if (bitcnt_q != 5'h1F) begin
                bitcnt_q <= bitcnt_q + 5'h01;
            end
        end
    end

    // readback: load once data is fetched, then shift on falling edges
    always @(posedge clk_in) begin
        if (rst_in) begin
            rd_load_q <= 1'b0;
            rd_shift_q <= 16'h0000;
            readback_out <= 1'b0;
        end else begin
            rd_load_q <= rd_issue;
            if (rd_load_q) begin
                rd_shift_q <= {mem_rdata[14:0], 1'b0};
                readback_out <= mem_rdata[15];
            end else if (csn_s) begin
                readback_out <= 1'b0;
            end else if (sclk_fall & (bitcnt_q > 5'h08)) begin
                rd_shift_q <= {rd_shift_q[14:0], 1'b0};
                readback_out <= rd_shift_q[15];
            end
        end
    end

    ssc_regmem #(
        .AW(`SSC_ADDR_BITS),
        .DW(`SSC_DATA_BITS)
    ) u_mem (
        .clk_in(clk_in),
        .clear_in(rst_in | soft_clr_q),
        .wr_in(wr_frame),
        .addr_in(mem_addr),
        .wdata_in(wr_data),
        .rdata_out(mem_rdata)
    );

    // ------------------------------------------------------------
    // shadow copies of the control registers
    // ------------------------------------------------------------
    reg [15:0] main_q;  // main control word
    reg [15:0] infmt_q; // input format word
    reg [15:0] dly_a_q; // delay words one and two
    reg [15:0] dly_b_q; // delay words three and four
    reg [15:0] frcfg_q; // frame-reference configuration
    reg [15:0] frdiv_q; // frame-reference divider

    // soft reset restores for one cycle; the reset bit clears itself
    always @(posedge clk_in) begin
        if (rst_in | soft_clr_q) begin
            main_q <= `SSC_RST_MAIN;
            infmt_q <= `SSC_RST_INFMT;
            dly_a_q <= `SSC_RST_DLY_A;
            dly_b_q <= `SSC_RST_DLY_B;
            frcfg_q <= `SSC_RST_FRCFG;
            frdiv_q <= `SSC_RST_FRDIV;
        end else if (wr_frame) begin
            case (wr_addr)
                `SSC_ADDR_MAIN: main_q <= wr_data;
                `SSC_ADDR_INFMT: infmt_q <= wr_data;
                `SSC_ADDR_DLY_A: dly_a_q <= wr_data;
                `SSC_ADDR_DLY_B: dly_b_q <= wr_data;
                `SSC_ADDR_FRCFG: frcfg_q <= wr_data;
                `SSC_ADDR_FRDIV: frdiv_q <= wr_data;
                default: main_q <= main_q;
            endcase
        end
    end

    // software reset request and calibration start pulse
    always @(posedge clk_in) begin
        if (rst_in) begin
            soft_clr_q <= 1'b0;
            calibration_start_out <= 1'b0;
        end else begin
            soft_clr_q <= main_q[`SSC_MAIN_RST] &
                ~main_q[`SSC_MAIN_PD] & ~soft_clr_q;
            calibration_start_out <= wr_frame &
                (wr_addr == `SSC_ADDR_MAIN) & wr_data[`SSC_MAIN_CAL];
        end
    end

    // ------------------------------------------------------------
    // device modes and input format
    // ------------------------------------------------------------
    wire pd = main_q[`SSC_MAIN_PD] | ~ce_s;
    wire repeat_select = frcfg_q[`SSC_FRCFG_REPEAT];
    wire pulsed = frcfg_q[`SSC_FRCFG_PULSED];
    wire [3:0] burst_pulse_count = frcfg_q[15:12];
    wire fmt_lvds = infmt_q[11:9] == `SSC_INFMT_LVDS;

    assign powerdown_out = pd;
    assign sync_feedback_out = main_q[`SSC_MAIN_PSYNC] & ~pd;
    assign frame_ref_mode_out = main_q[`SSC_MAIN_PSYNC] &
        frcfg_q[`SSC_FRCFG_EN] & ~pd;
    assign frame_ref_prediv_out = frcfg_q[7:5];
    assign lvds_in_en_out = fmt_lvds & repeat_select;
    assign input_bias_level_out = fmt_lvds ? infmt_q[8:7] : 2'h0;
    assign input_hysteresis_out = fmt_lvds & infmt_q[`SSC_INFMT_HYST];
    assign delay_interp_ctrl_out = {dly_b_q[11:0], dly_a_q[11:0]};

    // ------------------------------------------------------------
    // output clock model: one period is OUT_DIV fine steps
    // ------------------------------------------------------------
    reg [7:0] phase_q;   // fine step within the output period
    wire out_tick = (phase_q == 8'h00);

    always @(posedge clk_in) begin
        if (rst_in | pd) begin
            phase_q <= 8'h00;
            main_output_out <= 1'b0;
        end else begin
            phase_q <= (phase_q == OUT_DIV - 1) ? 8'h00 : phase_q + 8'h01;
            main_output_out <= (phase_q < OUT_DIV / 2);
        end
    end

    // ------------------------------------------------------------
    // request resampling and pulse sequencer
    // ------------------------------------------------------------
    reg req_ref_q;      // request sampled by reference clock
    reg req_out_q;      // then by the output clock
    reg req_prev_q;     // previous output-clock sample
    reg mode_prev_q;    // mode active last cycle
    reg [10:0] div_cnt_q; // output periods within one pulse period
    reg [4:0] left_q;   // pulses left in the burst
    reg raw_q;          // undelayed pulse level
    reg [15:0] dly_line_q; // fine-step delay line
    wire [3:0] steps_raw = dly_a_q[9:6];
    wire [31:0] max_steps_w = MAX_STEPS; // cap as a plain vector
    wire [3:0] steps = (steps_raw > max_steps_w[3:0]) ? max_steps_w[3:0] :
        steps_raw;
    wire [10:0] div_val = (frdiv_q[10:0] < 11'h002) ? 11'h002 :
        frdiv_q[10:0];
    wire mode_rise = frame_ref_mode_out & ~mode_prev_q;
    wire req_toggle = req_out_q ^ req_prev_q;
    wire running = ~pulsed | (left_q != 5'h00);

    always @(posedge clk_in) begin
        if (rst_in) begin
            req_ref_q <= 1'b1;
            req_out_q <= 1'b1;
            req_prev_q <= 1'b1;
        end else begin
            if (ref_tick) begin
                req_ref_q <= req_s;
            end
            if (out_tick) begin
                req_out_q <= req_ref_q;
                req_prev_q <= req_out_q;
            end
        end
    end

    // burst counter, period divider and pulse level
    always @(posedge clk_in) begin
        if (rst_in | ~frame_ref_mode_out) begin
            mode_prev_q <= 1'b0;
            div_cnt_q <= 11'h000;
            left_q <= 5'h00;
            raw_q <= 1'b0;
        end else begin
            mode_prev_q <= 1'b1;
            if ((mode_rise & ~repeat_select) |
                (out_tick & repeat_select & pulsed & req_toggle)) begin
                left_q <= {1'b0, burst_pulse_count};
                div_cnt_q <= 11'h000;
            end else if (out_tick) begin
                if (repeat_select & ~pulsed) begin
                    raw_q <= req_out_q;
                end else if (running) begin
                    div_cnt_q <= (div_cnt_q == div_val - 11'h001) ?
                        11'h000 : div_cnt_q + 11'h001;
                    raw_q <= (div_cnt_q < (div_val >> 1));
                    if (pulsed & (div_cnt_q == div_val - 11'h001)) begin
                        left_q <= left_q - 5'h01;
                    end
                end else begin
                    raw_q <= 1'b0;
                end
            end
        end
    end

    // phase adjust in sixteenths of the output period
    always @(posedge clk_in) begin
        if (rst_in) begin
            dly_line_q <= 16'h0000;
            secondary_output_out <= 1'b0;
        end else begin
            dly_line_q <= {dly_line_q[14:0], raw_q};
            secondary_output_out <= frame_ref_mode_out &
                ((steps == 4'h0) ? raw_q : dly_line_q[steps - 4'h1]);
        end
    end

endmodule

// ===== verification/ssc_ctrl_checker.sv
// checker of the serial port and mode outputs of ssc_ctrl
// assumes it sees only the top ports, attached by the bind at the foot
`timescale 1ns/1ps
module ssc_ctrl_checker (
    input wire clk_in, // block clock
    input wire rst_in, // synchronous reset
    input wire serial_select_n_in, // chip select pin, active low
    input wire chip_enable_in, // chip enable pin
    input wire readback_out, // serial read data
    input wire powerdown_out, // powered down
    input wire sync_feedback_out, // phase-sync mode
    input wire calibration_start_out, // calibration pulse
    input wire frame_ref_mode_out, // frame-reference mode
    input wire [2:0] frame_ref_prediv_out, // pre-divider field
    input wire [23:0] delay_interp_ctrl_out // delay words
);
    // ------------------------------------------------------------
    // clocking and sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // pins pass two flip-flops, so a few cycles of stable level are needed
    sequence s_ce_low;
        !chip_enable_in [*3];
    endsequence
    sequence s_select_idle;
        serial_select_n_in [*5];
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_pd_chip_low: assert property (s_ce_low |-> powerdown_out)
        else $error("powerdown missing with chip enable low");
    a_mode_needs_sync: assert property (
        frame_ref_mode_out |-> sync_feedback_out)
        else $error("reference mode without phase sync");
    a_cal_one_cycle: assert property (
        calibration_start_out |=> !calibration_start_out)
        else $error("calibration pulse longer than one cycle");
    a_readback_idle: assert property (s_select_idle |-> !readback_out)
        else $error("readback not low while deselected");
    a_reset_values: assert property ($fell(rst_in) |->
        delay_interp_ctrl_out == 24'h0006E4 && frame_ref_prediv_out == 3'h1)
        else $error("wrong values after reset");
    a_delay_on_commit: assert property (
        $changed(delay_interp_ctrl_out) |->
        serial_select_n_in && $past(serial_select_n_in, 2))
        else $error("delay words changed inside a frame");
    a_mode_on_commit: assert property (
        $changed(frame_ref_mode_out) || $changed(sync_feedback_out) |->
        serial_select_n_in && $past(serial_select_n_in, 2))
        else $error("mode changed inside a frame");
    a_cal_at_commit: assert property (
        calibration_start_out |-> serial_select_n_in)
        else $error("calibration pulse inside a frame");
endmodule

bind ssc_ctrl ssc_ctrl_checker u_chk (.*);

// ===== verification/ssc_host.sv
// host model: drives the serial programming port and the request pin
// assumes clk_in is the block clock; one serial clock period is 8 cycles
`timescale 1ns/1ps
module ssc_host (
    input wire clk_in,               // block clock
    input wire readback_in,          // serial read data of the device
    output reg serial_clk_out,       // serial clock, still outside frames
    output reg serial_data_out,      // serial data
    output reg serial_select_n_out,  // chip select, active low
    output reg pulse_request_pin_out // request pin
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        serial_select_n_out = 1'b1;
        pulse_request_pin_out = 1'b1; // held high in generator mode
    end

    // ------------------------------------------------------------
    // frame tasks
    // ------------------------------------------------------------
    // one frame msb first; fewer than 24 bits makes a refused frame
    task xfer(input [23:0] frame, input integer nbits, output [15:0] rd);
        integer i;
        begin
            rd = 16'h0000;
            @(posedge clk_in);
            serial_select_n_out <= 1'b0;
            for (i = 0; i < nbits; i = i + 1) begin
                serial_data_out <= frame[23 - i];
                repeat (4) @(posedge clk_in);
                serial_clk_out <= 1'b1;
                if (i >= 8) rd = {rd[14:0], readback_in};
                repeat (4) @(posedge clk_in);
                serial_clk_out <= 1'b0;
            end
            repeat (4) @(posedge clk_in);
            serial_select_n_out <= 1'b1;
            // a released line must not keep showing the last bit
            serial_data_out <= ~serial_data_out;
            // gap covers the commit latency and the minimum idle time
            repeat (8) @(posedge clk_in);
        end
    endtask
    task wr(input [6:0] addr, input [15:0] data);
        reg [15:0] unused;
        begin
            xfer({1'b0, addr, data}, 24, unused);
        end
    endtask
    task rd(input [6:0] addr, output [15:0] data);
        begin
            xfer({1'b1, addr, 16'h0000}, 24, data);
        end
    endtask
endmodule

// ===== verification/test_ssc_ctrl.sv
// self-checking bench of ssc_ctrl driven through the host model
// assumes a 50 ns block clock and an unrelated reference clock
`timescale 1ns/1ps
module test_ssc_ctrl;
    localparam OUT_DIV = 16; // output period in clk cycles
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg chip_enable_in = 1'b1;
    reg reference_clock_in = 1'b0;
    wire sclk, sdata, ssel_n, req, readback_out, powerdown_out;
    wire sync_feedback_out, calibration_start_out, frame_ref_mode_out;
    wire secondary_output_out, main_output_out, lvds_in_en_out;
    wire input_hysteresis_out;
    wire [2:0] frame_ref_prediv_out;
    wire [1:0] input_bias_level_out;
    wire [23:0] dly;
    integer cyc = 0, n_cal = 0, main_rise = 0, n_fail = 0, check_count = 0;
    reg main_q = 1'b0;

    // ------------------------------------------------------------
    // clocks, instances and monitors
    // ------------------------------------------------------------
    always #25 clk_in = ~clk_in;
    initial begin
        #7;
        forever #100 reference_clock_in = ~reference_clock_in;
    end
    ssc_host host (.clk_in(clk_in), .readback_in(readback_out),
        .serial_clk_out(sclk), .serial_data_out(sdata),
        .serial_select_n_out(ssel_n), .pulse_request_pin_out(req));
    ssc_ctrl #(.OUT_DIV(OUT_DIV)) dut (.*, .serial_clk_in(sclk),
        .serial_data_in(sdata), .serial_select_n_in(ssel_n),
        .pulse_request_pin_in(req), .delay_interp_ctrl_out(dly));
    // cycle count, main output edges, calibration pulses and the timeout
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        main_q <= main_output_out;
        if (main_output_out === 1'b1 && main_q === 1'b0) main_rise <= cyc;
        if (calibration_start_out === 1'b1) n_cal <= n_cal + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            complete_run;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [23:0] got, input [23:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // rising edges of the pulse output over a window of n cycles
    task count_rises(input integer n, output integer cnt);
        integer k;
        reg last;
        begin
            cnt = 0;
            last = secondary_output_out;
            for (k = 0; k < n; k = k + 1) begin
                @(posedge clk_in);
                if (secondary_output_out === 1'b1 && last === 1'b0) cnt++;
                last = secondary_output_out;
            end
        end
    endtask
    // bounded wait for a level on the pulse output; t is the cycle
    task wait_level(input v, output integer t);
        integer k;
        begin
            k = 0;
            while (secondary_output_out !== v && k < 300) begin
                @(posedge clk_in);
                k = k + 1;
            end
            t = cyc;
            chk(k < 300, 1'b1);
        end
    endtask
    // pulse period and offset of a rising edge within the output period
    task measure(output integer per, output integer off);
        integer t1, t2;
        begin
            repeat (2) begin
                wait_level(1'b0, t1);
                wait_level(1'b1, t1);
            end
            off = (t1 - main_rise) % OUT_DIV;
            wait_level(1'b0, t2);
            wait_level(1'b1, t2);
            per = t2 - t1;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin : main
        reg [15:0] d;
        integer per0, off0, per8, off8, i, c, n;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(dly, 24'h0006E4);
        chk({frame_ref_prediv_out, sync_feedback_out}, 4'h2);
        host.wr(7'h00, 16'h0002);
        host.wr(7'h00, 16'h0000);
        host.wr(7'h48, 16'h0002);
        host.wr(7'h47, 16'h0020);
        host.wr(7'h3D, 16'h0000);
        host.wr(7'h3C, 16'h0FC0);
        host.wr(7'h3A, 16'h0000);
        host.wr(7'h00, 16'h0008);
        chk(n_cal, 1);
        chk(dly, 24'h000FC0);
        host.rd(7'h3C, d);
        chk(d, 16'h0FC0);
        host.xfer({1'b1, 7'h3D, 16'h0FFF}, 24, d);
        chk(dly, 24'h000FC0);
        host.xfer({1'b0, 7'h3C, 16'h0000}, 23, d);
        chk(dly, 24'h000FC0);
        host.wr(7'h3D, 16'h0040);
        chk(dly, 24'h040FC0);
        host.wr(7'h00, 16'h0002);
        chk(dly, 24'h0006E4);
        host.wr(7'h00, 16'h0001);
        chk(powerdown_out, 1'b1);
        host.wr(7'h00, 16'h0000);
        chk(powerdown_out, 1'b0);
        chip_enable_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(powerdown_out, 1'b1);
        chip_enable_in <= 1'b1;
        host.wr(7'h3A, 16'h8300);
        chk({lvds_in_en_out, input_bias_level_out, input_hysteresis_out},
            4'h5);
        host.wr(7'h3A, 16'h8100);
        chk(input_bias_level_out, 2'h0);
        host.wr(7'h00, 16'h4000);
        chk({sync_feedback_out, frame_ref_mode_out}, 2'h2);
        host.wr(7'h47, 16'h0028);
        chk(frame_ref_mode_out, 1'b1);
        host.wr(7'h3C, 16'h081F);
        measure(per0, off0);
        chk(per0, 2 * OUT_DIV);
        host.wr(7'h3C, 16'h0A17);
        measure(per8, off8);
        chk((off8 - off0 + OUT_DIV) % OUT_DIV, 8);
        host.wr(7'h47, 16'h402C);
        host.pulse_request_pin_out <= 1'b0;
        wait_level(1'b0, n);
        host.pulse_request_pin_out <= 1'b1;
        wait_level(1'b1, n);
        host.wr(7'h3A, 16'h8300);
        chk(lvds_in_en_out, 1'b1);
        for (i = 0; i < 5; i = i + 1) begin
            c = (i == 0) ? 0 : (1 << (i - 1));
            host.wr(7'h47, {c[3:0], 12'h02E});
            host.pulse_request_pin_out <= ~host.pulse_request_pin_out;
            count_rises(400, n);
            chk(n, c);
        end
        complete_run;
    end
endmodule
